// File: verilog/cpr_clock_regs.vh
`ifndef CPR_CLOCK_REGS_VH
`define CPR_CLOCK_REGS_VH
// ratio strap encodings
`define CPR_CFG_4X5      4'h7
`define CPR_CFG_5X       4'hb
`define CPR_CFG_5X5      4'h9
`define CPR_CFG_6X       4'hd
`define CPR_CFG_6X5      4'h5
`define CPR_CFG_7X       4'h2
`define CPR_CFG_7X5      4'h1
`define CPR_CFG_8X       4'hc
`define CPR_CFG_9X       4'h0
`define CPR_CFG_BYPASS   4'h3
`define CPR_CFG_OFF      4'hf
// multipliers in half steps (core = bus * half / 2)
`define CPR_HALF_4X5     5'h09
`define CPR_HALF_5X      5'h0a
`define CPR_HALF_5X5     5'h0b
`define CPR_HALF_6X      5'h0c
`define CPR_HALF_6X5     5'h0d
`define CPR_HALF_7X      5'h0e
`define CPR_HALF_7X5     5'h0f
`define CPR_HALF_8X      5'h10
`define CPR_HALF_9X      5'h12
`define CPR_HALF_ONE     5'h02
`define CPR_HALF_NONE    5'h00
// vco runs at twice the core
`define CPR_VCO_PER_CORE 2
// clock modes
`define CPR_MODE_PLL     2'h0
`define CPR_MODE_BYPASS  2'h1
`define CPR_MODE_OFF     2'h2
`define CPR_MODE_RSVD    2'h3
// l2 divisor field codes, in half steps of core cycles
`define CPR_L2DIV_OFF    3'h0
`define CPR_L2DIV_MIN    4'h2
`define CPR_DLL_TAPS     8
`endif

// File: verilog/cpr_l2_divider.v
`timescale 1ns/1ps
`include "cpr_clock_regs.vh"
// divides the core clock enable stream by n/2, n = 2..8 (div 1 to div 4)
module cpr_l2_divider
#(
  parameter CW = 4
)
(
  input  wire          clk,       // reference clock
  input  wire          rst_n,     // async reset, low
  input  wire          core_tick, // one core edge this cycle
  input  wire [CW-1:0] half_div,  // divisor in half core cycles
  output reg           l2_clk     // divided l2 clock level
);
  reg [CW-1:0] cnt;
  wire [CW-1:0] next_cnt;
  // count half-core periods; toggle gives duty near half for odd counts
  assign next_cnt = (cnt >= half_div - {{(CW-1){1'b0}}, 1'b1}) ? {CW{1'b0}} : cnt + {{(CW-1){1'b0}}, 1'b1};
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt    <= {CW{1'b0}};
      l2_clk <= 1'b0;
    end
    else if (core_tick && half_div >= `CPR_L2DIV_MIN)
    begin
      cnt <= next_cnt;
      if (cnt == {CW{1'b0}})
        l2_clk <= 1'b1;
      else if (cnt == (half_div >> 1))
        l2_clk <= 1'b0;
    end
    else if (half_div < `CPR_L2DIV_MIN)
    begin
      cnt    <= {CW{1'b0}};
      l2_clk <= 1'b0;
    end
  end
endmodule

// File: verilog/cpr_clock_ctrl.v
`timescale 1ns/1ps
`include "cpr_clock_regs.vh"
// Notes on behaviour
// - the ratio strap decodes to core multipliers 4.5x to 9x of the bus clock, with the vco at twice the core.
// - the bypass code disables the pll and runs the core straight from the bus clock at 1:1.
// - the off code stops all internal clocking whatever the bus clock does.
// - the l2 clock is the core clock divided and then phase-aligned by a delay-locked loop.
// - a separate feedback clock goes out and returns so the loop can align the ram edge.
// - the l2 divisor comes from the l2 control register divisor field.
module cpr_clock_ctrl
#(
  parameter LOCK_CNT = 16 // dll matches needed before lock
)
(
  input  wire       REF_CLK,          // bus reference clock, 125 mhz
  input  wire       RESETN,           // async reset, low
  input  wire [3:0] RATIO_STRAP,      // ratio strap pins
  input  wire [2:0] L2_DIVISOR_FIELD, // divisor field of l2 control register
  input  wire       L2_FB_CLK_IN,     // returned feedback clock
  output reg  [1:0] CLOCK_MODE,       // pll, bypass, off, reserved
  output reg  [4:0] CORE_MULT_HALF,   // core multiplier in half steps
  output reg  [5:0] VCO_MULT_HALF,    // vco multiplier in half steps
  output reg        PLL_ENABLE,       // pll running
  output reg        CORE_CLK_EN,      // core clocking active
  output reg        STRAP_RESERVED,   // reserved code seen
  output reg        L2_CLK_OUT,       // aligned l2 clock to rams
  output reg        L2_FB_CLK_OUT,    // feedback clock out
  output reg        DLL_LOCKED        // delay line aligned
);
  // sequencer states
  localparam ST_RESET = 2'h0;
  localparam ST_RUN   = 2'h1;
  localparam ST_STOP  = 2'h2;
  // divider count width; eight delay taps need three select bits
  localparam CW       = 4;
  localparam TW       = 3;

  // captured strap and its decode
  reg  [1:0]               state;
  reg  [3:0]               strap;
  reg  [1:0]               next_mode;
  reg  [4:0]               next_half;

  // core edge model and l2 divider
  reg                      core_tick;
  reg  [CW-1:0]            half_div;
  wire                     l2_raw;

  // delay-locked loop; step_hold marks the compare right after a tap step
  reg  [`CPR_DLL_TAPS-1:0] dly;
  reg  [TW-1:0]            tap;
  reg  [7:0]               lock_cnt;
  reg                      step_hold;
  reg                      fb_match;
  reg                      next_step;

  // decode is combinational on the captured strap only
  always @*
  begin
    next_mode = `CPR_MODE_PLL;
    next_half = `CPR_HALF_NONE;
    case (strap)
      `CPR_CFG_4X5:    next_half = `CPR_HALF_4X5;
      `CPR_CFG_5X:     next_half = `CPR_HALF_5X;
      `CPR_CFG_5X5:    next_half = `CPR_HALF_5X5;
      `CPR_CFG_6X:     next_half = `CPR_HALF_6X;
      `CPR_CFG_6X5:    next_half = `CPR_HALF_6X5;
      `CPR_CFG_7X:     next_half = `CPR_HALF_7X;
      `CPR_CFG_7X5:    next_half = `CPR_HALF_7X5;
      `CPR_CFG_8X:     next_half = `CPR_HALF_8X;
      `CPR_CFG_9X:     next_half = `CPR_HALF_9X;
      `CPR_CFG_BYPASS:
      begin
        next_mode = `CPR_MODE_BYPASS; // 1:1 from bus clock
        next_half = `CPR_HALF_ONE;
      end
      `CPR_CFG_OFF:    next_mode = `CPR_MODE_OFF;
      default:         next_mode = `CPR_MODE_RSVD; // reserved code
    endcase
  end

  // strap caught once after release; later changes ignored since running change is illegal
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state          <= ST_RESET;
      strap          <= 4'h0;
      CLOCK_MODE     <= `CPR_MODE_OFF;
      CORE_MULT_HALF <= `CPR_HALF_NONE;
      VCO_MULT_HALF  <= 6'h00;
      PLL_ENABLE     <= 1'b0;
      CORE_CLK_EN    <= 1'b0;
      STRAP_RESERVED <= 1'b0;
    end
    else
    begin
      case (state)
        ST_RESET:
        begin
          strap <= RATIO_STRAP;
          state <= ST_STOP;
        end
        ST_STOP:
        begin
          CLOCK_MODE     <= next_mode;
          STRAP_RESERVED <= (next_mode == `CPR_MODE_RSVD);
          // reserved codes run nothing: safest reading of an illegal strap
          CORE_MULT_HALF <= next_half;
          VCO_MULT_HALF  <= (next_mode == `CPR_MODE_PLL) ? {next_half, 1'b0} : 6'h00;
          PLL_ENABLE     <= (next_mode == `CPR_MODE_PLL); // bypass keeps pll off
          CORE_CLK_EN    <= (next_mode == `CPR_MODE_PLL) || (next_mode == `CPR_MODE_BYPASS);
          state          <= ST_RUN;
        end
        ST_RUN:
          state <= ST_RUN;
        default:
          state <= ST_RESET;
      endcase
    end
  end

  // core edges modelled as one tick per ref cycle; the ratio shows only on the decode outputs
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      core_tick <= 1'b0;
      half_div  <= {CW{1'b0}};
    end
    else
    begin
      core_tick <= CORE_CLK_EN; // no ticks at all in off mode
      // one tick stands for one core edge, half a core period
      // limitation: fractional core ratios are not modelled here
      // field code 0 stops the l2 clock, codes 1..7 mean div 1..4 in half steps
      if (L2_DIVISOR_FIELD == `CPR_L2DIV_OFF)
        half_div <= {CW{1'b0}};
      else
        half_div <= {1'b0, L2_DIVISOR_FIELD} + 4'h1;
    end
  end

  // divide the core clock down for the rams
  cpr_l2_divider #(.CW(CW)) u_div
  (
    .clk       (REF_CLK),
    .rst_n     (RESETN),
    .core_tick (core_tick),
    .half_div  (half_div),
    .l2_clk    (l2_raw)
  );

  // delay line with tap chosen by the loop; both outputs share the tap
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      dly           <= {`CPR_DLL_TAPS{1'b0}};
      L2_CLK_OUT    <= 1'b0;
      L2_FB_CLK_OUT <= 1'b0;
    end
    else
    begin
      dly           <= {dly[`CPR_DLL_TAPS-2:0], l2_raw};
      L2_CLK_OUT    <= dly[tap];
      L2_FB_CLK_OUT <= dly[tap]; // separate feedback copy
    end
  end

  // a step shows on the returned clock one cycle late, so that cycle is not judged
  always @*
  begin
    fb_match  = (L2_FB_CLK_IN == l2_raw);
    next_step = !step_hold && !fb_match;
  end

  // skipping one compare after a step keeps the loop from running past the right tap
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
      step_hold <= 1'b0;
    else if (half_div < `CPR_L2DIV_MIN || !CORE_CLK_EN)
      step_hold <= 1'b0;
    else
      step_hold <= next_step;
  end

  // loop compares returned feedback with internal latch clock; step tap until they agree
  // limitation: total delay spans 2 to 9 cycles, so only l2 periods up to 9 cycles can be aligned
  always @(posedge REF_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tap        <= {TW{1'b0}};
      lock_cnt   <= 8'h00;
      DLL_LOCKED <= 1'b0;
    end
    else if (half_div < `CPR_L2DIV_MIN || !CORE_CLK_EN)
    begin
      lock_cnt   <= 8'h00;
      DLL_LOCKED <= 1'b0;
    end
    else if (step_hold)
      DLL_LOCKED <= 1'b0; // returned clock still shows the old tap
    else if (fb_match)
    begin
      if (lock_cnt != LOCK_CNT[7:0])
        lock_cnt <= lock_cnt + 8'h01;
      DLL_LOCKED <= (lock_cnt == LOCK_CNT[7:0]);
    end
    else
    begin
      tap        <= tap + {{(TW-1){1'b0}}, 1'b1}; // try the next delay
      lock_cnt   <= 8'h00;
      DLL_LOCKED <= 1'b0;
    end
  end
endmodule

// File: dv/cpr_clock_ctrl_monitor.sv
`timescale 1ns/1ps
module cpr_clock_ctrl_monitor (
  input wire       REF_CLK,          // clock
  input wire       RESETN,           // reset, low
  input wire [2:0] L2_DIVISOR_FIELD, // l2 divisor
  input wire [1:0] CLOCK_MODE,       // mode
  input wire [4:0] CORE_MULT_HALF,   // core mult
  input wire [5:0] VCO_MULT_HALF,    // vco mult
  input wire       PLL_ENABLE,       // pll on
  input wire       CORE_CLK_EN,      // core on
  input wire       STRAP_RESERVED,   // bad code
  input wire       L2_CLK_OUT,       // l2 clock
  input wire       L2_FB_CLK_OUT     // feedback out
);
  // one domain, so clock and reset are given once
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  // decode relations; mode stands until the next reset
  AST_VCO: assert property (PLL_ENABLE |-> VCO_MULT_HALF == {CORE_MULT_HALF, 1'b0} && CORE_MULT_HALF >= 5'h09)
    else $error("vco not twice core");
  AST_STAND: assert property (CORE_CLK_EN |=> $stable(CLOCK_MODE) && $stable(CORE_MULT_HALF))
    else $error("decode moved");
  AST_BYPASS: assert property (CLOCK_MODE == 2'h1 |-> CORE_CLK_EN && !PLL_ENABLE && CORE_MULT_HALF == 5'h02)
    else $error("bad bypass");
  AST_OFF: assert property (CLOCK_MODE == 2'h2 |-> !CORE_CLK_EN && !PLL_ENABLE && !L2_CLK_OUT)
    else $error("off still clocks");
  AST_RSVD: assert property (STRAP_RESERVED |-> CLOCK_MODE == 2'h3 && !CORE_CLK_EN)
    else $error("reserved clocks");
  // no core edges means nothing to divide
  AST_GATED: assert property (!CORE_CLK_EN |=> $stable(L2_CLK_OUT))
    else $error("l2 moves gated");
  AST_FB: assert property (L2_FB_CLK_OUT == L2_CLK_OUT)
    else $error("feedback differs");
  AST_DIV0: assert property ((L2_DIVISOR_FIELD == 3'h0) [*8] ##1 (L2_DIVISOR_FIELD == 3'h0) [*4] |=> $stable(L2_CLK_OUT))
    else $error("l2 runs at div 0");
endmodule
bind cpr_clock_ctrl cpr_clock_ctrl_monitor cpr_clock_ctrl_monitor_inst (.REF_CLK, .RESETN, .L2_DIVISOR_FIELD,
  .CLOCK_MODE, .CORE_MULT_HALF, .VCO_MULT_HALF, .PLL_ENABLE, .CORE_CLK_EN, .STRAP_RESERVED, .L2_CLK_OUT, .L2_FB_CLK_OUT);

// File: dv/cpr_board_model.sv
`timescale 1ns/1ps
// trace half way to the rams and back; line holds its driven level
module cpr_board_model (
  input  wire fb_out, // feedback clock from block
  output wire fb_in   // returned feedback clock
);
  // flight time only, so the loop sees the true ram edge
  assign #1 fb_in = fb_out;
endmodule

// File: dv/tb_cpr_clock_ctrl.sv
`timescale 1ns/1ps
module tb_cpr_clock_ctrl;
  reg        ref_clk;
  reg        resetn;
  reg  [3:0] strap;
  reg  [2:0] field;
  reg        p;
  wire       fb_in;
  wire [1:0] mode;
  wire [4:0] mult;
  wire [5:0] vco;
  wire       pll_en, core_en, rsvd, l2_clk, fb_out, locked;
  integer    miscompares, comparisons, i, n;
  // core multiplier in half steps, code f down to 0
  localparam [79:0] HALF = {5'h00, 5'h00, 5'h0c, 5'h10, 5'h0a, 5'h00, 5'h0b, 5'h00,
                            5'h09, 5'h00, 5'h0d, 5'h00, 5'h02, 5'h0e, 5'h0f, 5'h12};
  cpr_clock_ctrl #(.LOCK_CNT(4)) cpr_clock_ctrl_inst (.REF_CLK(ref_clk), .RESETN(resetn), .RATIO_STRAP(strap),
    .L2_DIVISOR_FIELD(field), .L2_FB_CLK_IN(fb_in), .CLOCK_MODE(mode), .CORE_MULT_HALF(mult),
    .VCO_MULT_HALF(vco), .PLL_ENABLE(pll_en), .CORE_CLK_EN(core_en), .STRAP_RESERVED(rsvd),
    .L2_CLK_OUT(l2_clk), .L2_FB_CLK_OUT(fb_out), .DLL_LOCKED(locked));
  cpr_board_model cpr_board_model_inst (.fb_out(fb_out), .fb_in(fb_in));
  // 125 mhz bus reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task check_val(input [7:0] got, input [7:0] exp);
  begin
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask
  task test_done;
  begin
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  // strap only enters through a reset
  task do_reset(input [3:0] c, input integer len);
  begin
    resetn = 1'b0;
    strap = c; // t_straps flips it after release to check it is ignored
    repeat (len) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
  end
  endtask
  // toggles over 64 cycles, after time for the loop to hunt through all taps and lock
  task count_edges(input [2:0] f);
  begin
    field = f;
    repeat (150) @(negedge ref_clk);
    n = 0;
    p = l2_clk;
    repeat (64)
    begin
      @(negedge ref_clk);
      if (l2_clk !== p)
        n = n + 1;
      p = l2_clk;
    end
  end
  endtask
  // every code, then a late strap change that must not land
  task t_straps;
  begin
    for (i = 0; i < 16; i = i + 1)
    begin
      do_reset(i[3:0], 2);
      n = (i == 3) ? 1 : (i == 15) ? 2 : (HALF[i*5 +: 5] == 0) ? 3 : 0;
      check_val(mode, n[7:0]);
      check_val(mult, HALF[i*5 +: 5]);
      check_val(vco, (n == 0) ? {HALF[i*5 +: 5], 1'b0} : 8'h00);
      check_val({pll_en, core_en, rsvd}, {n == 0, n < 2, n == 3});
      strap = ~strap;
      repeat (2) @(negedge ref_clk);
      check_val({mode, mult}, {n[1:0], HALF[i*5 +: 5]});
    end
  end
  endtask
  // l2 rate per divisor, then in bypass and off
  task t_l2;
  begin
    do_reset(4'h0, 2); // defined codes only
    count_edges(3'h3);
    check_val(n[7:0], 8'h20); // div 2 is four core edges a period
    check_val(locked, 8'h01);
    count_edges(3'h7);
    check_val(n[7:0], 8'h10);
    check_val(locked, 8'h01);
    count_edges(3'h0);
    check_val(n[7:0], 8'h00);
    do_reset(4'h3, 2);
    count_edges(3'h3);
    check_val(n[7:0], 8'h20);
    do_reset(4'hf, 2);
    count_edges(3'h3);
    check_val(n[7:0], 8'h00);
    check_val(locked, 8'h00);
  end
  endtask
  // main sequence
  initial
  begin
    miscompares = 0;
    comparisons = 0;
    field = 3'h0;
    do_reset(4'h0, 10); // power-up with a running code, never off
    t_straps;
    t_l2;
    test_done;
  end
  // watchdog, about ten times the roughly 1200 cycles needed
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    test_done;
  end
endmodule
